// ==== cpl_consts.svh ====
/*
 * constants for the cpu priority level control block: register byte offsets,
 * field positions, reset values and write masks.
 * assumes inclusion by bare name from every design file that needs them.
 */
`ifndef CPL_CONSTS_SVH
`define CPL_CONSTS_SVH

// ****************************************************************
// register byte offsets on the axi4-lite slave
// ****************************************************************
`define CPL_OFF_STATUS 8'h00
`define CPL_OFF_CORE 8'h04
`define CPL_OFF_INTCTL 8'h08
`define CPL_OFF_LEVEL 8'h0C

// ****************************************************************
// field positions
// ****************************************************************
`define CPL_PRIO_HI 7
`define CPL_PRIO_LO 5
`define CPL_MSB_BIT 3
`define CPL_NEST_BIT 15

// ****************************************************************
// reset values and write masks
// ****************************************************************
`define CPL_STATUS_RST 16'h0000
`define CPL_CORE_RST 16'h0020
`define CPL_INTCTL_RST 16'h0000
`define CPL_CORE_WMASK 16'h1FF7
`define CPL_INTCTL_WMASK 16'hFFFE
`define CPL_STATUS_WMASK 16'hFF1F
`define CPL_USER_MAX_LEVEL 4'h7

`endif

// ==== cpl_core_model.sv ====
/*
 * core-side partner: loads a new cpu level after a chosen delay.
 * assumes each call starts just after a rising edge of clk_in.
 */
`timescale 1ns/1ps
module cpl_core_model (
  input wire logic clk_in,
  output logic core_load_out,
  output logic [3:0] core_level_out
);
  // idle level is the inverse of the last one, never a held copy
  initial begin
    core_load_out = 1'h0;
    core_level_out = 4'h0;
  end
  task automatic load(input logic [3:0] v, input int dly);
    repeat (dly) @(posedge clk_in);
    core_load_out <= 1'h1;
    core_level_out <= v;
    @(posedge clk_in);
    core_load_out <= 1'h0;
    core_level_out <= ~v;
  endtask
endmodule // cpl_core_model

// ==== cpl_level_calc.sv ====
/*
 * combines the three-bit priority field and the level msb into a four-bit
 * cpu level and decides whether user interrupts are blocked.
 * assumes inputs come from registers on the same clock.
 */
`timescale 1ns/1ps
`include "cpl_consts.svh"

module cpl_level_calc (
  input wire logic [2:0] prio_field_in,
  input wire logic level_msb_in,
  output cpl_pkg::cpl_level_t cpu_level_out,
  output logic user_block_out
);
  // level msb sits above the field, giving 0..15
  assign cpu_level_out = {level_msb_in, prio_field_in}; // [R1] [R2]
  // msb alone blocks users; field 111 also blocks them
  assign user_block_out = level_msb_in | (prio_field_in == 3'h7); // [R3] [R1]
endmodule // cpl_level_calc

// ==== cpl_pkg.sv ====
/*
 * types shared by the cpu priority level control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package cpl_pkg;
  typedef enum logic [2:0] {
    CPL_WR_IDLE = 3'b001,
    CPL_WR_RESP = 3'b010,
    CPL_WR_WAIT = 3'b100
  } cpl_wr_state_t;
  typedef logic [3:0] cpl_level_t;
endpackage

// ==== cpl_priority_ctrl.sv ====
/*
 * cpu priority level control: status, core control and interrupt control
 * registers behind an axi4-lite slave, plus core-side update ports.
 * assumes one clock, an asynchronous active-high reset, and a core that
 * raises the level on interrupt entry through the core-side load port.
 */
`timescale 1ns/1ps
`include "cpl_consts.svh"

// Overview of operation
// [R1] three-bit field holds a binary cpu level, 111 disables user interrupts
// [R2] msb above the field forms a four-bit level, msb set adds eight
// [R3] user interrupts are blocked whenever the level msb is one
// [R4] field writes from software are ignored while nesting is disabled
// [R5] field at status bits 7..5, msb at core control bit 3
// [R6] msb reads one above level seven; software may only clear it
// [R7] nesting disable at interrupt control bit 15, resets to zero
// [R8] core control bits 15..13 read zero and ignore writes
// [R9] nesting is allowed whenever the nesting disable bit is zero
// [R10] software can never set the level msb
module cpl_priority_ctrl (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_load_in,
  input wire logic [3:0] core_level_in,
  output cpl_pkg::cpl_level_t cpu_level_out,
  output logic user_block_out,
  output logic nest_enable_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // merge a 16-bit write under byte strobes and a writable mask
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0] st,
                                          input logic [15:0] wm);
    logic [15:0] lane;
    lane = {{8{st[1]}}, {8{st[0]}}} & wm;
    merge16 = (old_v & ~lane) | (wd[15:0] & lane);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] status_reg, status_next;
  logic [15:0] core_reg, core_next;
  logic [15:0] intctl_reg, intctl_next;
  cpl_pkg::cpl_wr_state_t wst_reg, wst_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic aw_have_reg, aw_have_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic w_have_reg, w_have_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic nest_dis;
  logic do_write;

  assign nest_dis = intctl_reg[`CPL_NEST_BIT];
  assign nest_enable_out = ~nest_dis; // [R9]

  // level math shared with the core side
  cpl_level_calc u_calc (
    .prio_field_in(status_reg[`CPL_PRIO_HI:`CPL_PRIO_LO]), // [R5]
    .level_msb_in(core_reg[`CPL_MSB_BIT]),
    .cpu_level_out(cpu_level_out),
    .user_block_out(user_block_out)
  );

  // ****************************************************************
  // write channel: address and data taken in either order
  // ****************************************************************
  assign s_axi_awready = (wst_reg == cpl_pkg::CPL_WR_IDLE) & ~aw_have_reg;
  assign s_axi_wready = (wst_reg == cpl_pkg::CPL_WR_IDLE) & ~w_have_reg;
  assign s_axi_bvalid = (wst_reg == cpl_pkg::CPL_WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // next values for the write handshake
  always_comb begin
    awaddr_next = awaddr_reg;
    aw_have_next = aw_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    w_have_next = w_have_reg;
    wst_next = wst_reg;
    bresp_next = bresp_reg;
    do_write = 1'b0;
    case (wst_reg)
      cpl_pkg::CPL_WR_IDLE: begin
        if (s_axi_awvalid & s_axi_awready) begin
          awaddr_next = s_axi_awaddr;
          aw_have_next = 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
          w_have_next = 1'b1;
        end
        if (aw_have_reg & w_have_reg) begin
          wst_next = cpl_pkg::CPL_WR_WAIT;
        end
      end
      cpl_pkg::CPL_WR_WAIT: begin
        do_write = 1'b1;
        aw_have_next = 1'b0;
        w_have_next = 1'b0;
        bresp_next = 2'h0;
        case (awaddr_reg[7:2])
          6'(`CPL_OFF_STATUS >> 2), 6'(`CPL_OFF_CORE >> 2), 6'(`CPL_OFF_INTCTL >> 2),
          6'(`CPL_OFF_LEVEL >> 2): bresp_next = 2'h0;
          default: bresp_next = 2'h2; // unmapped: slave error
        endcase
        wst_next = cpl_pkg::CPL_WR_RESP;
      end
      cpl_pkg::CPL_WR_RESP: begin
        if (s_axi_bready) begin
          wst_next = cpl_pkg::CPL_WR_IDLE;
        end
      end
      default: wst_next = cpl_pkg::CPL_WR_IDLE;
    endcase
  end

  // ****************************************************************
  // register contents
  // ****************************************************************
  // software writes first, then the core-side load overrides the level
  always_comb begin
    status_next = status_reg;
    core_next = core_reg;
    intctl_next = intctl_reg;
    if (do_write) begin
      if (awaddr_reg[7:2] == 6'(`CPL_OFF_STATUS >> 2)) begin
        status_next = merge16(status_reg, wdata_reg, wstrb_reg, `CPL_STATUS_WMASK);
        if (!nest_dis && wstrb_reg[0]) begin
          status_next[`CPL_PRIO_HI:`CPL_PRIO_LO] =
            wdata_reg[`CPL_PRIO_HI:`CPL_PRIO_LO]; // [R4] [R5]
        end
      end
      if (awaddr_reg[7:2] == 6'(`CPL_OFF_CORE >> 2)) begin
        core_next = merge16(core_reg, wdata_reg, wstrb_reg, `CPL_CORE_WMASK); // [R8]
        if (wstrb_reg[0] && !wdata_reg[`CPL_MSB_BIT]) begin
          core_next[`CPL_MSB_BIT] = 1'b0; // [R6] [R10] clear only
        end
      end
      if (awaddr_reg[7:2] == 6'(`CPL_OFF_INTCTL >> 2)) begin
        intctl_next = merge16(intctl_reg, wdata_reg, wstrb_reg, `CPL_INTCTL_WMASK); // [R7]
      end
    end
    if (core_load_in) begin
      // core entry or return sets the full level; wins over software
      status_next[`CPL_PRIO_HI:`CPL_PRIO_LO] = core_level_in[2:0]; // [R2]
      core_next[`CPL_MSB_BIT] = core_level_in[3]; // [R6]
    end
    core_next[15:13] = 3'h0; // [R8]
  end

  // ****************************************************************
  // read channel: one-cycle registered answer
  // ****************************************************************
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // next values for the read answer
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      case (s_axi_araddr[7:2])
        6'(`CPL_OFF_STATUS >> 2): rdata_next = {16'h0000, status_reg};
        6'(`CPL_OFF_CORE >> 2): rdata_next = {16'h0000, 3'h0, core_reg[12:0]}; // [R8]
        6'(`CPL_OFF_INTCTL >> 2): rdata_next = {16'h0000, intctl_reg};
        6'(`CPL_OFF_LEVEL >> 2): rdata_next = {26'h0000000, nest_enable_out,
                                               user_block_out, cpu_level_out};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = 2'h2;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // all state, reset to constants
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_reg <= `CPL_STATUS_RST;
      core_reg <= `CPL_CORE_RST;
      intctl_reg <= `CPL_INTCTL_RST; // [R7]
      wst_reg <= cpl_pkg::CPL_WR_IDLE;
      awaddr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
      core_reg <= core_next;
      intctl_reg <= intctl_next;
      wst_reg <= wst_next;
      awaddr_reg <= awaddr_next;
      aw_have_reg <= aw_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      w_have_reg <= w_have_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

endmodule // cpl_priority_ctrl

// ==== cpl_priority_ctrl_chk.sv ====
/*
 * checker: level, blocking and bus timing relations of the priority block.
 * assumes a bind onto cpl_priority_ctrl, one clock, async active-high reset.
 */
`timescale 1ns/1ps
module cpl_priority_ctrl_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_load_in,
  input wire logic [3:0] core_level_in,
  input wire cpl_pkg::cpl_level_t cpu_level_out,
  input wire logic user_block_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // handshake steps of a write and of a read
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_load_level: assert property (core_load_in |=> cpu_level_out == $past(core_level_in))
    else $error("core level not shown");
  a_msb_blocks: assert property (cpu_level_out[3] |-> user_block_out)
    else $error("msb set but user open");
  a_top_blocks: assert property (cpu_level_out == 4'h7 |-> user_block_out)
    else $error("level seven not blocking");
  a_low_open: assert property (cpu_level_out < 4'h7 |-> !user_block_out)
    else $error("low level blocking");
  a_msb_core_only: assert property ($rose(cpu_level_out[3]) |-> $past(core_load_in))
    else $error("msb set without core load");
  a_write_answer: assert property (s_wr_both |-> ##3 s_axi_bvalid)
    else $error("write answer late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
endmodule // cpl_priority_ctrl_chk

bind cpl_priority_ctrl cpl_priority_ctrl_chk u_chk (.clk_in, .sys_rst_in, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_load_in, .core_level_in,
  .cpu_level_out, .user_block_out);

// ==== cpu_priority_level_control_bench.sv ====
/*
 * bench: register model with core loads and axi4-lite traffic, compared at each result.
 * assumes the design, the checker bind and the core partner are compiled first.
 */
`timescale 1ns/1ps
`include "cpl_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module cpu_priority_level_control_bench;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, core_level_in;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, core_load_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic user_block_out, nest_enable_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  cpl_pkg::cpl_level_t cpu_level_out;
  logic [31:0] sts = `CPL_STATUS_RST, cor = `CPL_CORE_RST, ict = `CPL_INTCTL_RST;
  int errors = 0, comparisons = 0, seed = 44;
  // clock
  always #5 clk_in = ~clk_in;
  cpl_core_model core (.clk_in, .core_load_out(core_load_in), .core_level_out(core_level_in));
  cpl_priority_ctrl dut (.clk_in, .sys_rst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_load_in, .core_level_in, .cpu_level_out,
    .user_block_out, .nest_enable_out);
  // ****************************************************************
  // model and bus tasks
  // ****************************************************************
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      `CPL_OFF_STATUS: return sts;
      `CPL_OFF_CORE: return cor;
      `CPL_OFF_INTCTL: return ict;
      `CPL_OFF_LEVEL: return {26'h0, ~ict[15], cor[3] | &sts[7:5], cor[3], sts[7:5]};
      default: return 32'h0;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    logic [15:0] m;
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    {tb, n} = {1'h0, 32'h0};
    while (!tb) begin
      @(negedge clk_in);
      {ta, tw, tb} = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_bvalid};
      @(posedge clk_in);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (++n > 50) begin errors++; tally_and_finish(); end
    end
    s_axi_bready <= 1'h0;
    `CHK(s_axi_bresp, (a <= 8'h0C) ? 2'h0 : 2'h2)
    // let an edge pass so the next call does not reassign bready in this step
    @(posedge clk_in);
    m = {{8{s[1]}}, {8{s[0]}}};
    if (a == `CPL_OFF_STATUS) begin
      sts[15:0] = (sts[15:0] & ~(m & `CPL_STATUS_WMASK)) | (d[15:0] & m & `CPL_STATUS_WMASK);
      if (s[0] && !ict[15]) sts[7:5] = d[7:5];
    end
    if (a == `CPL_OFF_CORE) begin
      cor[15:0] = (cor[15:0] & ~(m & `CPL_CORE_WMASK)) | (d[15:0] & m & `CPL_CORE_WMASK);
      if (s[0] && !d[3]) cor[3] = 1'h0;
    end
    if (a == `CPL_OFF_INTCTL)
      ict[15:0] = (ict[15:0] & ~(m & `CPL_INTCTL_WMASK)) | (d[15:0] & m & `CPL_INTCTL_WMASK);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    {tv, n} = {1'h0, 32'h0};
    while (!tv) begin
      @(negedge clk_in);
      {ta, tv} = {s_axi_arready, s_axi_rvalid};
      if (tv) `CHK(s_axi_rdata, exp_rd(a))
      if (tv) `CHK(s_axi_rresp, (a <= 8'h0C) ? 2'h0 : 2'h2)
      @(posedge clk_in);
      if (ta) s_axi_arvalid <= 1'h0;
      if (++n > 50) begin errors++; tally_and_finish(); end
    end
    s_axi_rready <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic ck();
    @(negedge clk_in);
    `CHK(cpu_level_out, {cor[3], sts[7:5]})
    `CHK(user_block_out, cor[3] | &sts[7:5])
    `CHK(nest_enable_out, ~ict[15])
    @(posedge clk_in);
  endtask
  task automatic ld(input logic [3:0] v, input int dly);
    core.load(v, dly);
    {cor[3], sts[7:5]} = v;
    ck();
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r, d;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(posedge clk_in);
    for (int a = 0; a <= 16; a += 4) rd(a[7:0]);
    ck();
    $display("reset test done");
    for (int v = 0; v < 16; v++) begin
      ld(v[3:0], v % 3);
      rd(`CPL_OFF_STATUS);
      rd(`CPL_OFF_CORE);
      rd(`CPL_OFF_LEVEL);
    end
    $display("level test done");
    ld(4'h5, 0);
    wr(`CPL_OFF_CORE, 32'hFFFF, 4'h3);
    rd(`CPL_OFF_CORE);
    ld(4'hD, 1);
    wr(`CPL_OFF_CORE, 32'h0, 4'h1);
    rd(`CPL_OFF_CORE);
    ck();
    $display("msb test done");
    for (int k = 0; k < 2; k++) begin
      wr(`CPL_OFF_INTCTL, k ? 32'h0 : 32'h8000, 4'h3);
      wr(`CPL_OFF_STATUS, k ? 32'h0060 : 32'h00E0, 4'h1);
      rd(`CPL_OFF_STATUS);
      ck();
    end
    $display("nesting test done");
    repeat (60) begin
      r = $random(seed);
      d = $random(seed);
      if (r[1:0] == 2'h0) d[4] = 1'h0;
      if (r[4]) ld(r[11:8], r[13:12]);
      else wr((r[1:0] == 2'h3) ? 8'h10 : {4'h0, r[1:0], 2'h0}, d, r[7:4]);
      rd({4'h0, r[15:14], 2'h0});
      ck();
    end
    $display("random test done");
    tally_and_finish();
  end
endmodule // cpu_priority_level_control_bench
